// file: pbc_bus_ctl.sv
`default_nettype none
// What this block does
// - Master asserts frame to start, holds while continuing
// - Frame deasserted means final data phase
// - Data moves only when both readies asserted
// - Either ready missing inserts wait cycles
// - Master ready when it can take/give data
// - Target ready when it can give/take data
// - Device select driven only after own decode
// - Target stop forces master to terminate
// - Data parity mismatch asserts parity error
// - Address parity error on open-drain system error
// - Interrupt line open-drain, low while requesting
// - Bus signals sampled on rising clock edge
// - Even parity valid one clock after phase
module pbc_bus_ctl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire pbc_pkg::pbc_ctl_t ctl_in,
  output pbc_pkg::pbc_ctl_t ctl_out,
  output pbc_pkg::pbc_ctl_t ctl_oe_n,
  input wire logic [31:0] ad_in,
  input wire logic [3:0] cbe_in,
  input wire logic par_in,
  output logic par_out,
  output logic par_oe_n,
  output logic serr_out,
  output logic serr_oe_n,
  output logic inta_out,
  output logic inta_oe_n,
  input wire pbc_pkg::pbc_drv_t drv,
  input wire pbc_pkg::pbc_mreq_t mreq,
  input wire pbc_pkg::pbc_treq_t treq,
  input wire logic irq_req,
  input wire logic perr_en,
  input wire logic serr_en,
  output pbc_pkg::pbc_stat_t stat
);
  import pbc_pkg::*;

  pbc_mst_t m_st_q, m_st_d;
  pbc_tgt_t t_st_q, t_st_d;
  pbc_perr_t p_st_q, p_st_d;
  pbc_ctl_t ctl_q, ctl_d, oe_q, oe_d;
  pbc_stat_t stat_q, stat_d;
  logic [2:0] tmo_q, tmo_d;
  logic m_write_q, m_write_d, t_write_q, t_write_d;
  logic frame_prev_q, addr_q, rx_q, rx_d;
  logic [31:0] ad_q;
  logic [3:0] cbe_q;
  logic par_q, par_d, par_oe_n_q, serr_oe_n_q, serr_oe_n_d, inta_oe_n_q, od_q;
  logic addr_phase, stop_seen, m_xfer, t_xfer, par_bad;

  // --------------------------------------------------------
  // Bus observation
  // --------------------------------------------------------
  // Pins are on this clock, so they are used as sampled at the edge
  assign addr_phase = !ctl_in.frame && frame_prev_q && (m_st_q == PBC_M_IDLE);
  assign stop_seen = !ctl_in.stop && !ctl_in.devsel;
  assign m_xfer = (m_st_q == PBC_M_DATA) && !ctl_q.irdy && !ctl_in.trdy;
  assign t_xfer = (t_st_q == PBC_T_DATA) && !ctl_q.trdy && !ctl_in.irdy;
  assign par_bad = ^{ad_q, cbe_q, par_in};

  // --------------------------------------------------------
  // Master, target and error signalling
  // --------------------------------------------------------
  always_comb begin
    m_st_d = m_st_q;
    t_st_d = t_st_q;
    p_st_d = p_st_q;
    ctl_d = ctl_q;
    oe_d = oe_q;
    tmo_d = tmo_q;
    m_write_d = m_write_q;
    t_write_d = t_write_q;
    stat_d = PBC_STAT_RST;
    case (m_st_q)
      PBC_M_IDLE: begin
        oe_d.frame = 1'b1;
        oe_d.irdy = 1'b1;
        if (mreq.start && ctl_in.frame && ctl_in.irdy && t_st_q == PBC_T_IDLE) begin
          ctl_d.frame = 1'b0;
          ctl_d.irdy = 1'b1;
          oe_d.frame = 1'b0;
          oe_d.irdy = 1'b0;
          tmo_d = PBC_TMO_RST;
          m_write_d = mreq.write;
          m_st_d = PBC_M_ADDR;
        end
      end
      PBC_M_ADDR: begin
        ctl_d.irdy = !mreq.ready;
        ctl_d.frame = mreq.ready && mreq.last;
        m_st_d = PBC_M_DATA;
      end
      PBC_M_DATA: begin
        if (ctl_in.devsel) begin
          tmo_d = tmo_q + 3'h1;
        end
        if (ctl_in.devsel && tmo_q == PBC_DEVSEL_TMO) begin
          // Nobody claimed the access: give up
          ctl_d.frame = 1'b1;
          ctl_d.irdy = 1'b1;
          stat_d.m_abort = 1'b1;
          m_st_d = PBC_M_TURN;
        end else if (ctl_q.irdy) begin
          ctl_d.irdy = !mreq.ready;
          ctl_d.frame = ctl_q.frame || (mreq.ready && mreq.last);
        end else if (ctl_q.frame && (!ctl_in.trdy || stop_seen)) begin
          ctl_d.irdy = 1'b1;
          stat_d.m_abort = stop_seen;
          m_st_d = PBC_M_TURN;
        end else if (stop_seen) begin
          ctl_d.frame = 1'b1;
          stat_d.m_abort = 1'b1;
        end else if (!ctl_in.trdy) begin
          ctl_d.irdy = !mreq.ready;
          ctl_d.frame = mreq.ready && mreq.last;
        end
      end
      PBC_M_TURN: begin
        oe_d.frame = 1'b1;
        oe_d.irdy = 1'b1;
        m_st_d = PBC_M_IDLE;
      end
      default: begin
        m_st_d = PBC_M_IDLE;
      end
    endcase
    case (t_st_q)
      PBC_T_IDLE: begin
        oe_d.trdy = 1'b1;
        oe_d.devsel = 1'b1;
        oe_d.stop = 1'b1;
        if (addr_phase && treq.hit) begin
          ctl_d.devsel = 1'b0;
          ctl_d.trdy = 1'b1;
          ctl_d.stop = 1'b1;
          oe_d.trdy = 1'b0;
          oe_d.devsel = 1'b0;
          oe_d.stop = 1'b0;
          t_write_d = cbe_in[0];
          t_st_d = PBC_T_DATA;
        end
      end
      PBC_T_DATA: begin
        if (!ctl_in.irdy && ctl_in.frame && (!ctl_q.trdy || !ctl_q.stop)) begin
          ctl_d.trdy = 1'b1;
          ctl_d.devsel = 1'b1;
          ctl_d.stop = 1'b1;
          t_st_d = PBC_T_TURN;
        end else if (!ctl_q.trdy && ctl_in.irdy) begin
          ctl_d.trdy = 1'b0;
          ctl_d.stop = !treq.stop;
        end else begin
          ctl_d.trdy = !treq.ready;
          ctl_d.stop = !treq.stop;
        end
      end
      PBC_T_TURN: begin
        oe_d.trdy = 1'b1;
        oe_d.devsel = 1'b1;
        oe_d.stop = 1'b1;
        t_st_d = PBC_T_IDLE;
      end
      default: begin
        t_st_d = PBC_T_IDLE;
      end
    endcase
    // Report is two clocks after the data phase, then parked high
    case (p_st_q)
      PBC_P_IDLE: begin
        oe_d.perr = 1'b1;
        ctl_d.perr = 1'b1;
        if (perr_en && rx_q && par_bad) begin
          ctl_d.perr = 1'b0;
          oe_d.perr = 1'b0;
          stat_d.perr_seen = 1'b1;
          p_st_d = PBC_P_LOW;
        end
      end
      PBC_P_LOW: begin
        ctl_d.perr = 1'b1;
        p_st_d = PBC_P_HIGH;
      end
      PBC_P_HIGH: begin
        oe_d.perr = 1'b1;
        p_st_d = PBC_P_IDLE;
      end
      default: begin
        p_st_d = PBC_P_IDLE;
      end
    endcase
    stat_d.m_busy = (m_st_d != PBC_M_IDLE);
    stat_d.m_xfer = m_xfer;
    stat_d.t_busy = (t_st_d != PBC_T_IDLE);
    stat_d.t_xfer = t_xfer;
    stat_d.t_write = t_write_d;
    stat_d.serr_seen = serr_en && addr_q && par_bad;
  end

  // --------------------------------------------------------
  // Parity, system error and interrupt
  // --------------------------------------------------------
  always_comb begin
    rx_d = (t_xfer && t_write_q) || (m_xfer && !m_write_q);
    par_d = ^{drv.ad, drv.cbe};
    serr_oe_n_d = !(serr_en && addr_q && par_bad);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m_st_q <= PBC_M_IDLE;
      t_st_q <= PBC_T_IDLE;
      p_st_q <= PBC_P_IDLE;
      ctl_q <= PBC_CTL_RST;
      oe_q <= PBC_OE_RST;
      stat_q <= PBC_STAT_RST;
      tmo_q <= PBC_TMO_RST;
      m_write_q <= 1'b0;
      t_write_q <= 1'b0;
      frame_prev_q <= 1'b1;
      addr_q <= 1'b0;
      rx_q <= 1'b0;
      ad_q <= 32'h0000_0000;
      cbe_q <= 4'h0;
      par_q <= 1'b0;
      par_oe_n_q <= 1'b1;
      serr_oe_n_q <= 1'b1;
      inta_oe_n_q <= 1'b1;
      od_q <= PBC_OD_LOW;
    end else if (ce) begin
      m_st_q <= m_st_d;
      t_st_q <= t_st_d;
      p_st_q <= p_st_d;
      ctl_q <= ctl_d;
      oe_q <= oe_d;
      stat_q <= stat_d;
      tmo_q <= tmo_d;
      m_write_q <= m_write_d;
      t_write_q <= t_write_d;
      frame_prev_q <= ctl_in.frame;
      addr_q <= !ctl_in.frame && frame_prev_q;
      rx_q <= rx_d;
      ad_q <= ad_in;
      cbe_q <= cbe_in;
      par_q <= par_d;
      par_oe_n_q <= !drv.oe;
      serr_oe_n_q <= serr_oe_n_d;
      inta_oe_n_q <= !irq_req;
      od_q <= PBC_OD_LOW;
    end
  end

  assign ctl_out = ctl_q;
  assign ctl_oe_n = oe_q;
  assign par_out = par_q;
  assign par_oe_n = par_oe_n_q;
  assign serr_out = od_q;
  assign serr_oe_n = serr_oe_n_q;
  assign inta_out = od_q;
  assign inta_oe_n = inta_oe_n_q;
  assign stat = stat_q;

  // --------------------------------------------------------
  // Checks
  // --------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);

  a_frame_start_hold: assert property (m_st_q == PBC_M_ADDR |-> !ctl_q.frame && !oe_q.frame)
    else $error("frame not asserted in address phase");
  a_frame_last_irdy: assert property ((m_st_q == PBC_M_DATA) && $rose(ctl_q.frame) |-> !ctl_q.irdy)
    else $error("frame removed without initiator ready");
  a_xfer_both_ready: assert property (stat_q.m_xfer |-> $past(!ctl_q.irdy && !ctl_in.trdy))
    else $error("master transfer without both readies");
  a_irdy_wait_hold: assert property (m_st_q == PBC_M_DATA && !ctl_q.irdy && ctl_in.trdy && !stop_seen
    && !ctl_in.devsel |=> !ctl_q.irdy)
    else $error("initiator ready dropped during wait");
  a_irdy_on_ready: assert property (m_st_q == PBC_M_ADDR && mreq.ready |=> !ctl_q.irdy)
    else $error("initiator ready late");
  a_trdy_on_ready: assert property (t_st_q == PBC_T_DATA && ctl_q.trdy && ctl_q.stop && treq.ready |=> !ctl_q.trdy)
    else $error("target ready not given");
  a_devsel_claim: assert property ($fell(ctl_q.devsel) |-> $past(addr_phase && treq.hit))
    else $error("device select without decode");
  a_stop_ends: assert property (m_st_q == PBC_M_DATA && !ctl_q.irdy && stop_seen |-> ##[1:2] ctl_q.frame)
    else $error("master ignored stop");
  a_perr_report: assert property (perr_en && rx_q && par_bad && p_st_q == PBC_P_IDLE
    |=> !ctl_q.perr && !oe_q.perr ##1 ctl_q.perr ##1 oe_q.perr)
    else $error("parity error not reported");
  a_serr_open_drain: assert property (!serr_oe_n |-> !serr_out && $past(addr_q && par_bad))
    else $error("system error misdriven");
  a_inta_follow: assert property (inta_oe_n == !$past(irq_req) && !inta_out)
    else $error("interrupt line wrong");
  a_par_even: assert property (!par_oe_n |-> par_out == ^$past({drv.ad, drv.cbe}))
    else $error("generated parity wrong");
  a_turn_high: assert property (t_st_q == PBC_T_TURN |-> ctl_q.trdy && ctl_q.devsel && ctl_q.stop
    && !oe_q.devsel ##1 oe_q.devsel)
    else $error("target released lines while asserted");

  c_master_burst: cover property (stat_q.m_xfer ##1 stat_q.m_xfer);
  c_target_write: cover property (stat_q.t_xfer && t_write_q);
  c_master_abort: cover property (stat_q.m_abort);
  c_parity_err: cover property (stat_q.perr_seen);
endmodule
`default_nettype wire

// file: pbc_bus_ctl_tb.sv
`default_nettype none
module pbc_bus_ctl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pbc_pkg::*;
  // Row bits: bad parity, dut master, write, claim, stop, wait[2:0], phases[1:0], abort
  typedef logic [10:0] pbc_row_t;
  localparam pbc_row_t ROWS [8] = '{11'h282, 11'h392, 11'h2AA, 11'h301, 11'h2C9, 11'h182, 11'h082, 11'h1C0};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pbc_ctl_t bus, ctl_out, ctl_oe_n, p_o, p_e;
  logic [35:0] adc, adc_q = 36'h0, p_adc;
  logic par, par_q = 1'b0, par_out, par_oe_n, serr_out, serr_oe_n, inta_out, inta_oe_n, p_aoe, p_par, p_pe;
  logic irq_req = 1'b0, perr_en = 1'b1, claim = 1'b0, t_stop = 1'b0, m_go = 1'b0, m_write = 1'b0, bad_par = 1'b0;
  logic [2:0] t_wait = 3'h0;
  logic ce = 1'b1;
  pbc_drv_t drv = '0;
  pbc_mreq_t mreq = '0;
  pbc_treq_t treq = '0;
  pbc_stat_t stat;
  int err_count = 0, tests_run = 0, m_x, t_x, m_a, pe_c, se_c, ph, fr_c, ps_c, ss_c;
  always #2.5 clk = ~clk;
  // --------------------
  // Wires and monitor
  // --------------------
  // Released control lines are pulled up
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      bus[i] = !ctl_oe_n[i] ? ctl_out[i] : (!p_e[i] ? p_o[i] : 1'b1);
    end
  end
  // Floating lines show the inverse of their last level
  assign adc = drv.oe ? {drv.ad, drv.cbe} : (p_aoe ? p_adc : ~adc_q);
  assign par = !par_oe_n ? par_out : (!p_pe ? p_par : ~par_q);
  always @(posedge clk) begin
    adc_q <= adc;
    par_q <= par;
    if (stat.m_xfer === 1'b1) m_x++;
    if (stat.t_xfer === 1'b1) t_x++;
    if (stat.m_abort === 1'b1) m_a++;
    if (bus.perr === 1'b0) pe_c++;
    if (serr_oe_n === 1'b0 && serr_out === 1'b0) se_c++;
    if (bus.irdy === 1'b0 && bus.trdy === 1'b0) ph++;
    if (bus.frame === 1'b0) fr_c++;
    if (stat.perr_seen === 1'b1) ps_c++;
    if (stat.serr_seen === 1'b1) ss_c++;
  end
  pbc_bus_ctl u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .ctl_in(bus), .ctl_out(ctl_out), .ctl_oe_n(ctl_oe_n),
    .ad_in(adc[35:4]), .cbe_in(adc[3:0]), .par_in(par), .par_out(par_out), .par_oe_n(par_oe_n),
    .serr_out(serr_out), .serr_oe_n(serr_oe_n), .inta_out(inta_out), .inta_oe_n(inta_oe_n), .drv(drv),
    .mreq(mreq), .treq(treq), .irq_req(irq_req), .perr_en(perr_en), .serr_en(1'b1), .stat(stat));
  pbc_far_model u_far (.clk(clk), .rst_n(rst_n), .bus(bus), .bus_adc(adc), .claim(claim), .t_wait(t_wait),
    .t_stop(t_stop), .m_go(m_go), .m_write(m_write), .bad_par(bad_par), .p_o(p_o), .p_e(p_e), .p_adc(p_adc),
    .p_aoe(p_aoe), .p_par(p_par), .p_pe(p_pe));
  // --------------------
  // Tasks
  // --------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d, comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic launch(input pbc_row_t r);
    @(posedge clk);
    {m_x, t_x, m_a, pe_c, se_c, ph, fr_c, ps_c, ss_c} = '0;
    bad_par <= r[10];
    claim <= r[7];
    t_stop <= r[6];
    t_wait <= r[5:3];
    m_write <= r[8];
    treq <= {1'b1, !r[6], r[6]};
    drv <= {r[9], 32'h5A5A0F0F, 3'h3, r[8]};
    mreq <= {r[9], r[8], 2'h3};
    m_go <= !r[9];
    @(posedge clk);
    mreq.start <= 1'b0;
    m_go <= 1'b0;
    // Own address phase is driven; on reads the lines go to the target after it
    @(posedge clk);
    drv.oe <= r[9] & r[8];
  endtask
  task automatic settle();
    repeat (24) @(posedge clk);
    #1;
  endtask
  task automatic run(input pbc_row_t r);
    launch(r);
    settle();
    chk(8'(r[9] ? m_x : t_x), 8'(r[2:1]), "user phases");
    chk(8'(ph), 8'(r[2:1]), "wire phases");
    chk(8'(fr_c), 8'h01, "frame span");
    chk(8'(m_a), 8'(r[0]), "abort");
    chk(8'(pe_c + se_c), 8'h00, "stray error");
    chk(8'(ctl_oe_n), 8'h3F, "lines held");
    chk({5'h00, stat.m_busy, stat.t_busy, stat.t_write && !r[9]}, 8'(r[8] && !r[9]), "status");
  endtask
  // --------------------
  // Sequence
  // --------------------
  initial begin
    repeat (12) @(posedge clk);
    #1;
    chk(8'(ctl_oe_n), 8'h3F, "reset lines");
    chk({5'h00, par_oe_n, serr_oe_n, inta_oe_n}, 8'h07, "reset pins");
    chk(8'(stat), 8'h00, "reset status");
    @(posedge clk);
    rst_n <= 1'b1;
    foreach (ROWS[i]) run(ROWS[i]);
    // Address error as target, data error as master, then reporting off
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      perr_en <= (i != 2);
      launch(i == 0 ? 11'h582 : 11'h682);
      settle();
      chk(8'(pe_c != 0), 8'(i != 2), "parity report");
      chk(8'(se_c), 8'(i == 0), "system error");
      chk(8'(ps_c), 8'(i != 2), "parity status");
      chk(8'(ss_c), 8'(i == 0), "system status");
    end
    @(posedge clk);
    irq_req <= 1'b1;
    @(posedge clk);
    #1;
    chk({6'h00, inta_oe_n, inta_out}, 8'h00, "irq on");
    @(posedge clk);
    irq_req <= 1'b0;
    @(posedge clk);
    #1;
    chk({6'h00, inta_oe_n, inta_out}, 8'h02, "irq off");
    // Enable low: a request must not reach the pin
    @(posedge clk);
    ce <= 1'b0;
    irq_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({6'h00, inta_oe_n, inta_out}, 8'h02, "irq frozen");
    @(posedge clk);
    irq_req <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    launch(11'h2AA);
    repeat (3) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk(8'(ctl_oe_n), 8'h3F, "reset in transfer");
    @(posedge clk);
    rst_n <= 1'b1;
    run(ROWS[0]);
    summarize();
  end
  // Run needs about 360 cycles
  initial begin
    #20000;
    $display("wrong value at %0t: watchdog expired", $time);
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire

// file: pbc_far_model.sv
`default_nettype none
module pbc_far_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire pbc_pkg::pbc_ctl_t bus,
  input wire logic [35:0] bus_adc,
  input wire logic claim,
  input wire logic [2:0] t_wait,
  input wire logic t_stop,
  input wire logic m_go,
  input wire logic m_write,
  input wire logic bad_par,
  output pbc_pkg::pbc_ctl_t p_o,
  output pbc_pkg::pbc_ctl_t p_e,
  output logic [35:0] p_adc,
  output logic p_aoe,
  output logic p_par,
  output logic p_pe
);
  timeunit 1ns;
  timeprecision 1ps;
  import pbc_pkg::*;
  logic [1:0] ts;
  logic [1:0] ms;
  logic [2:0] cnt;
  logic fr_q;
  // --------------------
  // Far target and master
  // --------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ts <= 2'h0;
      ms <= 2'h0;
      cnt <= 3'h0;
      fr_q <= 1'b1;
      p_o <= '1;
      p_e <= '1;
      p_adc <= 36'h0;
      p_aoe <= 1'b0;
      p_par <= 1'b0;
      p_pe <= 1'b1;
    end else begin
      fr_q <= bus.frame;
      // Taken from the resolved lines, so right whoever drives them, and inverted when bad_par is set
      p_par <= ^bus_adc ^ bad_par;
      p_pe <= !p_aoe;
      case (ts)
        2'h0: if (fr_q && !bus.frame && ms == 2'h0 && claim) begin
          ts <= 2'h1;
          cnt <= t_wait;
          p_o.devsel <= 1'b0;
          p_e <= 6'h31;
          p_aoe <= !bus_adc[0];
          p_adc <= 36'hC3C35A5A0;
        end
        2'h1: if (!bus.irdy && bus.frame && !(bus.trdy && bus.stop)) begin
          p_o <= '1;
          p_aoe <= 1'b0;
          ts <= 2'h2;
        end else if (cnt != 3'h0) begin
          cnt <= cnt - 3'h1;
        end else begin
          p_o.trdy <= t_stop;
          p_o.stop <= !t_stop;
        end
        default: begin
          p_e <= '1;
          ts <= 2'h0;
        end
      endcase
      case (ms)
        2'h0: if (m_go && bus.frame && bus.irdy && ts == 2'h0) begin
          ms <= 2'h1;
          cnt <= PBC_DEVSEL_TMO;
          p_o.frame <= 1'b0;
          p_e.frame <= 1'b0;
          p_e.irdy <= 1'b0;
          p_aoe <= 1'b1;
          p_adc <= {32'h00002000, 3'h3, m_write};
        end
        2'h1: begin
          p_o.frame <= 1'b1;
          p_o.irdy <= 1'b0;
          p_aoe <= m_write;
          p_adc <= 36'h1234ABCD0;
          ms <= 2'h2;
        end
        2'h2: if (!bus.trdy || !bus.stop || cnt == 3'h0) begin
          p_o.irdy <= 1'b1;
          p_aoe <= 1'b0;
          ms <= 2'h3;
        end else if (bus.devsel) begin
          cnt <= cnt - 3'h1;
        end
        default: begin
          p_e.frame <= 1'b1;
          p_e.irdy <= 1'b1;
          ms <= 2'h0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: pbc_pkg.sv
`default_nettype none
package pbc_pkg;
  // Bus control pins, wire level (low = asserted)
  typedef struct packed {
    logic frame;
    logic irdy;
    logic trdy;
    logic devsel;
    logic stop;
    logic perr;
  } pbc_ctl_t;

  typedef struct packed {
    logic start;
    logic write;
    logic last;
    logic ready;
  } pbc_mreq_t;

  typedef struct packed {
    logic hit;
    logic ready;
    logic stop;
  } pbc_treq_t;

  typedef struct packed {
    logic oe;
    logic [31:0] ad;
    logic [3:0] cbe;
  } pbc_drv_t;

  typedef struct packed {
    logic m_busy;
    logic m_xfer;
    logic m_abort;
    logic t_busy;
    logic t_xfer;
    logic t_write;
    logic perr_seen;
    logic serr_seen;
  } pbc_stat_t;

  typedef enum logic [1:0] {
    PBC_M_IDLE = 2'b00,
    PBC_M_ADDR = 2'b01,
    PBC_M_DATA = 2'b10,
    PBC_M_TURN = 2'b11
  } pbc_mst_t;

  typedef enum logic [1:0] {
    PBC_T_IDLE = 2'b00,
    PBC_T_DATA = 2'b01,
    PBC_T_TURN = 2'b10
  } pbc_tgt_t;

  typedef enum logic [1:0] {
    PBC_P_IDLE = 2'b00,
    PBC_P_LOW = 2'b01,
    PBC_P_HIGH = 2'b10
  } pbc_perr_t;

  localparam pbc_ctl_t PBC_CTL_RST = 6'h3F;
  localparam pbc_ctl_t PBC_OE_RST = 6'h3F;
  localparam pbc_stat_t PBC_STAT_RST = 8'h00;
  localparam logic PBC_OD_LOW = 1'b0;
  localparam logic [2:0] PBC_DEVSEL_TMO = 3'h5;
  localparam logic [2:0] PBC_TMO_RST = 3'h0;
endpackage
`default_nettype wire
